//--- verilog/csb_pkg.sv
// Package for the per-core sideband block: register map, field layout,
// reset values and the carrier types that travel between its parts.
// Assumes a four-core cluster on a single clock domain.
package csb_pkg;

  localparam int CSB_CORES     = 4;
  localparam int CSB_ADDR_W    = 8;
  localparam int CSB_DATA_W    = 32;
  localparam int CSB_SHARED_N  = 479;
  localparam int CSB_SHARED_STEP = 32;

  // Register byte addresses
  localparam logic [7:0] CSB_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CSB_STATUS_OFS = 8'h04;
  localparam logic [7:0] CSB_IRQLV_OFS  = 8'h08;
  localparam logic [7:0] CSB_BASE_OFS   = 8'h0C;
  localparam logic [7:0] CSB_SECCFG_OFS = 8'h10;
  localparam logic [7:0] CSB_CNTLO_OFS  = 8'h14;
  localparam logic [7:0] CSB_CNTHI_OFS  = 8'h18;

  // Control fields
  localparam int CSB_CTRL_NOPD_LSB = 0;
  localparam logic [3:0] CSB_CTRL_RST = 4'h0;
  localparam logic [31:0] CSB_SECCFG_RST = 32'h0000_0000;

  // Status fields
  localparam int CSB_ST_WFINT_LSB = 0;
  localparam int CSB_ST_WFEVT_LSB = 4;
  localparam int CSB_ST_L2_BIT    = 8;
  localparam int CSB_ST_SNOOP_BIT = 9;
  localparam int CSB_ST_LOCK_BIT  = 10;
  localparam int CSB_ST_DBG_LSB   = 12;

  // Interrupt level fields
  localparam int CSB_LV_FAST_LSB   = 0;
  localparam int CSB_LV_NORMAL_LSB = 4;
  localparam int CSB_LV_VFAST_LSB  = 8;
  localparam int CSB_LV_VNORM_LSB  = 12;
  localparam int CSB_LV_SHARED_BIT = 16;

  // Peripheral base strap
  localparam int CSB_BASE_MSB = 39;
  localparam int CSB_BASE_LSB = 15;
  localparam int CSB_BASE_W   = CSB_BASE_MSB - CSB_BASE_LSB + 1;

  // Synchronised pin group: irq pins 15:0, wake 16, snoop 17, lock 18, debug 22:19
  localparam int CSB_ASYNC_W = 23;
  localparam logic [22:0] CSB_ASYNC_RST = 23'h00FFFF;
  localparam int CSB_A_WAKE  = 16;
  localparam int CSB_A_SNOOP = 17;
  localparam int CSB_A_LOCK  = 18;
  localparam int CSB_A_DBG   = 19;

  // Strap capture waits out the two synchroniser stages
  localparam logic [1:0] CSB_STRAP_DONE = 2'h3;

  typedef struct packed {
    logic [3:0] fast;
    logic [3:0] normal;
    logic [3:0] vfast;
    logic [3:0] vnormal;
  } csb_irq_t;

  typedef struct packed {
    logic [3:0] hyp;
    logic [3:0] nonsec;
    logic [3:0] sec;
    logic [3:0] virt;
  } csb_timer_t;

  // Per-core OR of every interrupt kind
  function automatic logic [3:0] csb_irq_any(input csb_irq_t v);
    csb_irq_any = v.fast | v.normal | v.vfast | v.vnormal;
  endfunction

endpackage

//--- verilog/csb_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words are not coherent.
`timescale 1ns/1ps
module csb_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

//--- verilog/csb_sideband.sv
// Per-core interrupt, timer-event and power sideband of a four-core cluster.
// Assumes core-side strobes are synchronous to CLOCK; pins are asynchronous.
// Function
// - Bit i of every four-bit per-core signal belongs to core i.
// - Shared interrupt input is N+1 wide; N = 31..479 step 32, or 0.
// - Secure config lock refuses writes to the secure register.
// - Fast interrupt pins are active low levels, held until acknowledged.
// - Normal interrupt pins are active low levels, held until acknowledged.
// - Virtual interrupt pins are active low and may change asynchronously.
// - Forward distributor fast requests per core, active low.
// - Forward distributor normal requests per core, active low.
// - Capture peripheral base bits 39..15 into the base register at reset.
// - Four active low timer event outputs per core.
// - Wake event input ends wait-for-event standby.
// - Event output pulses when any core sends an event.
// - Wait-for-interrupt standby bit is 1 only while that core stands by.
// - Wait-for-event standby bit is 1 only while that core stands by.
// - L2 standby only when all cores idle, snoop inactive, L2 idle.
// - No-power-down flag per core stops the power controller.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module csb_sideband
  import csb_pkg::*;
#(
  parameter int SHARED_N = CSB_SHARED_N
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESETN,
  input  wire logic [CSB_ADDR_W-1:0] ADDR,
  input  wire logic [CSB_DATA_W-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [CSB_DATA_W-1:0] RDATA,
  input  wire logic                  SECURE_CFG_WRITE_LOCK,
  input  wire logic [SHARED_N:0]     SHARED_IRQ_LINES,
  output logic      [SHARED_N:0]     SHARED_IRQ_SYNC,
  input  wire logic [3:0]            FAST_IRQ_REQ_N,
  input  wire logic [3:0]            NORMAL_IRQ_REQ_N,
  input  wire logic [3:0]            VIRT_FAST_IRQ_REQ_N,
  input  wire logic [3:0]            VIRT_NORMAL_IRQ_REQ_N,
  input  wire logic [3:0]            DIST_FAST_IRQ,
  input  wire logic [3:0]            DIST_NORMAL_IRQ,
  output logic      [3:0]            FAST_IRQ_FWD_N,
  output logic      [3:0]            NORMAL_IRQ_FWD_N,
  output csb_irq_t                   CORE_IRQ_LEVELS,
  input  wire logic [39:15]          PERIPH_BASE_ADDR,
  input  wire csb_timer_t            TIMER_FIRE,
  output logic      [3:0]            HYP_PHYS_TIMER_EVT_N,
  output logic      [3:0]            NONSEC_PHYS_TIMER_EVT_N,
  output logic      [3:0]            SEC_PHYS_TIMER_EVT_N,
  output logic      [3:0]            VIRT_TIMER_EVT_N,
  input  wire logic [63:0]           SYSTEM_COUNT_VALUE,
  input  wire logic                  WAKE_EVENT_IN,
  output logic                       SEND_EVENT_OUT,
  input  wire logic [3:0]            CORE_SEND_EVENT,
  input  wire logic [3:0]            CORE_WFI_ENTER,
  input  wire logic [3:0]            CORE_WFE_ENTER,
  output logic      [3:0]            CORE_WAKE,
  output logic      [3:0]            CORE_WFINT_STANDBY,
  output logic      [3:0]            CORE_WFEVT_STANDBY,
  output logic                       L2_WFINT_STANDBY,
  input  wire logic                  SNOOP_INACTIVE,
  input  wire logic                  L2_IDLE,
  input  wire logic [3:0]            DEBUG_POWERUP_REQ,
  output logic      [3:0]            NO_POWERDOWN_FLAG
);

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // Pin synchronisers
  logic [CSB_ASYNC_W-1:0] async_in;
  logic [CSB_ASYNC_W-1:0] async_q;
  logic [CSB_BASE_W-1:0]  base_q;

  assign async_in = {DEBUG_POWERUP_REQ, SECURE_CFG_WRITE_LOCK, SNOOP_INACTIVE,
                     WAKE_EVENT_IN, VIRT_NORMAL_IRQ_REQ_N, VIRT_FAST_IRQ_REQ_N,
                     NORMAL_IRQ_REQ_N, FAST_IRQ_REQ_N};

  csb_sync #(
    .W       (CSB_ASYNC_W),
    .RST_VAL (CSB_ASYNC_RST)
  ) u_pin_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .d     (async_in),
    .q     (async_q)
  );

  // Width follows SHARED_N; only 0 and 31 + k*32 up to 479 are legal
  csb_sync #(
    .W       (SHARED_N + 1),
    .RST_VAL ('0)
  ) u_shared_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .d     (SHARED_IRQ_LINES),
    .q     (SHARED_IRQ_SYNC)
  );

  csb_sync #(
    .W       (CSB_BASE_W),
    .RST_VAL ('0)
  ) u_base_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .d     (PERIPH_BASE_ADDR),
    .q     (base_q)
  );

  // Unpacked pin levels, active high inside
  csb_irq_t   pin_req;
  csb_irq_t   core_req;
  logic       wake_lvl;
  logic       snoop_lvl;
  logic       lock_lvl;
  logic [3:0] dbg_lvl;
  logic       shared_any;

  // Levels pass straight through: no latching, the source holds until taken
  assign pin_req.fast    = ~async_q[3:0];
  assign pin_req.normal  = ~async_q[7:4];
  assign pin_req.vfast   = ~async_q[11:8];
  assign pin_req.vnormal = ~async_q[15:12];
  assign wake_lvl   = async_q[CSB_A_WAKE];
  assign snoop_lvl  = async_q[CSB_A_SNOOP];
  assign lock_lvl   = async_q[CSB_A_LOCK];
  assign dbg_lvl    = async_q[CSB_A_DBG +: 4];
  assign shared_any = |SHARED_IRQ_SYNC;

  assign core_req.fast    = pin_req.fast | DIST_FAST_IRQ;
  assign core_req.normal  = pin_req.normal | DIST_NORMAL_IRQ;
  assign core_req.vfast   = pin_req.vfast;
  assign core_req.vnormal = pin_req.vnormal;

  // Standby tracking
  logic       wake_prev_reg;
  logic       wake_pulse;
  logic       evt_hit;
  logic [3:0] irq_any;
  logic [3:0] evt_latch_reg;
  logic [3:0] evt_latch_next;
  logic [3:0] wfe_skip;
  logic [3:0] wfint_reg;
  logic [3:0] wfint_next;
  logic [3:0] wfevt_reg;
  logic [3:0] wfevt_next;
  logic [3:0] wake_reg;
  logic [3:0] wake_next;
  logic       l2_reg;
  logic       l2_next;
  logic       send_evt_reg;

  assign wake_pulse = wake_lvl & ~wake_prev_reg;
  assign evt_hit    = wake_pulse | (|CORE_SEND_EVENT);
  assign irq_any    = csb_irq_any(core_req);

  // An event seen outside standby is kept so the next wait returns at once
  assign evt_latch_next = (evt_latch_reg | ({4{evt_hit}} & ~wfevt_reg))
                          & ~CORE_WFE_ENTER;
  assign wfe_skip   = CORE_WFE_ENTER & (evt_latch_reg | {4{evt_hit}} | irq_any);
  assign wfevt_next = (wfevt_reg | (CORE_WFE_ENTER & ~wfe_skip))
                      & ~({4{evt_hit}} | irq_any);
  // A pending interrupt beats a request to stand by
  assign wfint_next = (wfint_reg | CORE_WFI_ENTER) & ~irq_any;
  assign wake_next  = (wfint_reg & ~wfint_next) | (wfevt_reg & ~wfevt_next)
                      | wfe_skip;
  // Uses next state so L2 standby never outlives a core's standby
  assign l2_next    = (&wfint_next) & snoop_lvl & L2_IDLE;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      wake_prev_reg <= 1'b0;
      evt_latch_reg <= 4'h0;
      wfint_reg     <= 4'h0;
      wfevt_reg     <= 4'h0;
      wake_reg      <= 4'h0;
      l2_reg        <= 1'b0;
      send_evt_reg  <= 1'b0;
    end else begin
      wake_prev_reg <= wake_lvl;
      evt_latch_reg <= evt_latch_next;
      wfint_reg     <= wfint_next;
      wfevt_reg     <= wfevt_next;
      wake_reg      <= wake_next;
      l2_reg        <= l2_next;
      send_evt_reg  <= |CORE_SEND_EVENT;
    end
  end

  // Forwarding and timer events
  logic [3:0] fast_fwd_reg;
  logic [3:0] normal_fwd_reg;
  csb_irq_t   lvl_reg;
  csb_timer_t tmr_reg;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      fast_fwd_reg   <= 4'hF;
      normal_fwd_reg <= 4'hF;
      lvl_reg        <= '0;
      tmr_reg        <= '1;
    end else begin
      fast_fwd_reg   <= ~DIST_FAST_IRQ;
      normal_fwd_reg <= ~DIST_NORMAL_IRQ;
      lvl_reg        <= core_req;
      // Held inverted so each event pin leaves a flop with no gate behind it
      tmr_reg        <= ~TIMER_FIRE;
    end
  end

  // Register port
  logic        wr_ctrl;
  logic        wr_sec;
  logic        rd_cntlo;
  logic [3:0]  ctrl_reg;
  logic [31:0] seccfg_reg;
  logic [31:0] cnt_hold_reg;
  logic [CSB_BASE_W-1:0] base_reg;
  logic [1:0]  strap_cnt_reg;
  logic [31:0] status_word;
  logic [31:0] lvl_word;
  logic [31:0] rd_mux;
  logic [31:0] rdata_reg;

  assign wr_ctrl  = WR && (ADDR == CSB_CTRL_OFS);
  assign wr_sec   = WR && (ADDR == CSB_SECCFG_OFS) && !lock_lvl;
  assign rd_cntlo = RD && (ADDR == CSB_CNTLO_OFS);

  assign status_word = {16'h0000,
                        dbg_lvl,
                        1'b0,
                        lock_lvl,
                        snoop_lvl,
                        l2_reg,
                        wfevt_reg,
                        wfint_reg};

  assign lvl_word = {15'h0000,
                     shared_any,
                     lvl_reg.vnormal,
                     lvl_reg.vfast,
                     lvl_reg.normal,
                     lvl_reg.fast};

  // Reading the low count word freezes the high word for a coherent pair
  assign rd_mux =
    (ADDR == CSB_CTRL_OFS)   ? {28'h0000000, ctrl_reg} :
    (ADDR == CSB_STATUS_OFS) ? status_word :
    (ADDR == CSB_IRQLV_OFS)  ? lvl_word :
    (ADDR == CSB_BASE_OFS)   ? {7'h00, base_reg} :
    (ADDR == CSB_SECCFG_OFS) ? seccfg_reg :
    (ADDR == CSB_CNTLO_OFS)  ? SYSTEM_COUNT_VALUE[31:0] :
    (ADDR == CSB_CNTHI_OFS)  ? cnt_hold_reg :
    32'h0000_0000;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= CSB_CTRL_RST;
      seccfg_reg   <= CSB_SECCFG_RST;
      cnt_hold_reg <= 32'h0000_0000;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= WDATA[CSB_CTRL_NOPD_LSB +: 4];
      end
      if (wr_sec) begin
        seccfg_reg <= WDATA;
      end
      if (rd_cntlo) begin
        cnt_hold_reg <= SYSTEM_COUNT_VALUE[63:32];
      end
      rdata_reg <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  // Strap capture after the synchroniser has filled
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= 2'h0;
      base_reg      <= '0;
    end else if (strap_cnt_reg != CSB_STRAP_DONE) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      base_reg      <= base_q;
    end
  end

  // Outputs
  assign RDATA                   = rdata_reg;
  assign FAST_IRQ_FWD_N          = fast_fwd_reg;
  assign NORMAL_IRQ_FWD_N        = normal_fwd_reg;
  assign CORE_IRQ_LEVELS         = lvl_reg;
  assign HYP_PHYS_TIMER_EVT_N    = tmr_reg.hyp;
  assign NONSEC_PHYS_TIMER_EVT_N = tmr_reg.nonsec;
  assign SEC_PHYS_TIMER_EVT_N    = tmr_reg.sec;
  assign VIRT_TIMER_EVT_N        = tmr_reg.virt;
  assign SEND_EVENT_OUT          = send_evt_reg;
  assign CORE_WAKE               = wake_reg;
  assign CORE_WFINT_STANDBY      = wfint_reg;
  assign CORE_WFEVT_STANDBY      = wfevt_reg;
  assign L2_WFINT_STANDBY        = l2_reg;
  assign NO_POWERDOWN_FLAG       = ctrl_reg;

endmodule

//--- dv/csb_sideband_asserts.sv
// Concurrent checks on the sideband block's ports, bound to its top module.
// Assumes pins have settled for the synchroniser depth after reset release.
`timescale 1ns/1ps
module csb_sideband_asserts
  import csb_pkg::*;
(
  input wire logic                  CLOCK,
  input wire logic                  RESETN,
  input wire logic [CSB_ADDR_W-1:0] ADDR,
  input wire logic [CSB_DATA_W-1:0] WDATA,
  input wire logic                  WR,
  input wire logic [3:0]            FAST_IRQ_REQ_N,
  input wire logic [3:0]            VIRT_FAST_IRQ_REQ_N,
  input wire logic [3:0]            DIST_FAST_IRQ,
  input wire logic [3:0]            DIST_NORMAL_IRQ,
  input wire logic [3:0]            FAST_IRQ_FWD_N,
  input wire logic [3:0]            NORMAL_IRQ_FWD_N,
  input wire csb_irq_t              CORE_IRQ_LEVELS,
  input wire csb_timer_t            TIMER_FIRE,
  input wire logic [3:0]            HYP_PHYS_TIMER_EVT_N,
  input wire logic [3:0]            NONSEC_PHYS_TIMER_EVT_N,
  input wire logic [3:0]            SEC_PHYS_TIMER_EVT_N,
  input wire logic [3:0]            VIRT_TIMER_EVT_N,
  input wire logic                  SEND_EVENT_OUT,
  input wire logic [3:0]            CORE_SEND_EVENT,
  input wire logic [3:0]            CORE_WFI_ENTER,
  input wire logic [3:0]            CORE_WFE_ENTER,
  input wire logic [3:0]            CORE_WFINT_STANDBY,
  input wire logic [3:0]            CORE_WFEVT_STANDBY,
  input wire logic                  L2_WFINT_STANDBY,
  input wire logic                  SNOOP_INACTIVE,
  input wire logic                  L2_IDLE,
  input wire logic [3:0]            NO_POWERDOWN_FLAG
);
  logic [2:0] up_cnt_reg;
  wire        rdy;
  // Internal reset and pin synchronisers lag RESETN, so checks wait them out
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  assign rdy = (up_cnt_reg == 3'h7);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_evt_sent; CORE_SEND_EVENT != 4'h0; endsequence
  sequence s_parked; rdy && CORE_WFEVT_STANDBY != 4'h0; endsequence
  property p_fast_fwd; rdy |-> FAST_IRQ_FWD_N == ~$past(DIST_FAST_IRQ); endproperty
  a_fast_fwd: assert property (p_fast_fwd) else $error("fast forward wrong");
  property p_norm_fwd; rdy |-> NORMAL_IRQ_FWD_N == ~$past(DIST_NORMAL_IRQ); endproperty
  a_norm_fwd: assert property (p_norm_fwd) else $error("normal forward wrong");
  property p_timer; rdy |-> {HYP_PHYS_TIMER_EVT_N, NONSEC_PHYS_TIMER_EVT_N,
    SEC_PHYS_TIMER_EVT_N, VIRT_TIMER_EVT_N} == ~$past(TIMER_FIRE); endproperty
  a_timer: assert property (p_timer) else $error("timer event wrong");
  property p_sev; rdy |-> SEND_EVENT_OUT == (|$past(CORE_SEND_EVENT)); endproperty
  a_sev: assert property (p_sev) else $error("event out wrong");
  property p_l2; rdy |-> L2_WFINT_STANDBY == (&CORE_WFINT_STANDBY
    && $past(SNOOP_INACTIVE, 3) && $past(L2_IDLE)); endproperty
  a_l2: assert property (p_l2) else $error("l2 standby wrong");
  property p_wfi_rise; rdy |-> (CORE_WFINT_STANDBY & ~$past(CORE_WFINT_STANDBY)
    & ~$past(CORE_WFI_ENTER)) == 4'h0; endproperty
  a_wfi_rise: assert property (p_wfi_rise) else $error("wfi standby uncaused");
  property p_wfe_rise; rdy |-> (CORE_WFEVT_STANDBY & ~$past(CORE_WFEVT_STANDBY)
    & ~$past(CORE_WFE_ENTER)) == 4'h0; endproperty
  a_wfe_rise: assert property (p_wfe_rise) else $error("wfe standby uncaused");
  property p_wfe_wake; s_parked ##0 s_evt_sent |=> CORE_WFEVT_STANDBY == 4'h0; endproperty
  a_wfe_wake: assert property (p_wfe_wake) else $error("event missed standby");
  property p_vfast; rdy |-> CORE_IRQ_LEVELS.vfast == ~$past(VIRT_FAST_IRQ_REQ_N, 3); endproperty
  a_vfast: assert property (p_vfast) else $error("virtual level wrong");
  property p_fast; rdy |-> CORE_IRQ_LEVELS.fast ==
    (~$past(FAST_IRQ_REQ_N, 3) | $past(DIST_FAST_IRQ)); endproperty
  a_fast: assert property (p_fast) else $error("fast level wrong");
  property p_nopd_wr; rdy && $past(WR) && $past(ADDR) == CSB_CTRL_OFS
    |-> NO_POWERDOWN_FLAG == $past(WDATA[3:0]); endproperty
  a_nopd_wr: assert property (p_nopd_wr) else $error("flag not written");
  property p_nopd_hold; rdy && !($past(WR) && $past(ADDR) == CSB_CTRL_OFS)
    |-> $stable(NO_POWERDOWN_FLAG); endproperty
  a_nopd_hold: assert property (p_nopd_hold) else $error("flag moved");
endmodule

bind csb_sideband csb_sideband_asserts csb_sideband_asserts_i (
  .CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .FAST_IRQ_REQ_N(FAST_IRQ_REQ_N), .VIRT_FAST_IRQ_REQ_N(VIRT_FAST_IRQ_REQ_N),
  .DIST_FAST_IRQ(DIST_FAST_IRQ), .DIST_NORMAL_IRQ(DIST_NORMAL_IRQ),
  .FAST_IRQ_FWD_N(FAST_IRQ_FWD_N), .NORMAL_IRQ_FWD_N(NORMAL_IRQ_FWD_N),
  .CORE_IRQ_LEVELS(CORE_IRQ_LEVELS), .TIMER_FIRE(TIMER_FIRE),
  .HYP_PHYS_TIMER_EVT_N(HYP_PHYS_TIMER_EVT_N), .NONSEC_PHYS_TIMER_EVT_N(NONSEC_PHYS_TIMER_EVT_N),
  .SEC_PHYS_TIMER_EVT_N(SEC_PHYS_TIMER_EVT_N), .VIRT_TIMER_EVT_N(VIRT_TIMER_EVT_N),
  .SEND_EVENT_OUT(SEND_EVENT_OUT), .CORE_SEND_EVENT(CORE_SEND_EVENT),
  .CORE_WFI_ENTER(CORE_WFI_ENTER), .CORE_WFE_ENTER(CORE_WFE_ENTER),
  .CORE_WFINT_STANDBY(CORE_WFINT_STANDBY), .CORE_WFEVT_STANDBY(CORE_WFEVT_STANDBY),
  .L2_WFINT_STANDBY(L2_WFINT_STANDBY), .SNOOP_INACTIVE(SNOOP_INACTIVE),
  .L2_IDLE(L2_IDLE), .NO_POWERDOWN_FLAG(NO_POWERDOWN_FLAG)
);

//--- dv/csb_power_model.sv
// Power controller and interrupt source model on the far side of the block.
// Assumes the bench holds each interrupt command until the core has taken it.
`timescale 1ns/1ps
module csb_power_model
  import csb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire csb_irq_t   irq_cmd,
  input  wire logic       snoop_cmd,
  input  wire logic [3:0] dbg_cmd,
  input  wire logic [3:0] pd_req,
  input  wire logic [3:0] no_pd,
  output logic      [3:0] fast_n,
  output logic      [3:0] normal_n,
  output logic      [3:0] vfast_n,
  output logic      [3:0] vnorm_n,
  output logic            snoop_out,
  output logic      [3:0] dbg_out,
  output logic     [63:0] count,
  output logic      [3:0] core_off
);
  // High word stays put for the whole run, so a paired read is predictable
  localparam logic [63:0] COUNT_START = 64'h1234_5678_0000_0000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count     <= COUNT_START;
      {fast_n, normal_n, vfast_n, vnorm_n} <= 16'hFFFF;
      snoop_out <= 1'b0;
      dbg_out   <= 4'h0;
    end else begin
      count     <= count + 64'h1;
      fast_n    <= ~irq_cmd.fast;
      normal_n  <= ~irq_cmd.normal;
      vfast_n   <= ~irq_cmd.vfast;
      vnorm_n   <= ~irq_cmd.vnormal;
      snoop_out <= snoop_cmd;
      dbg_out   <= dbg_cmd;
    end
  end
  assign core_off = pd_req & ~no_pd;
endmodule

//--- dv/csb_sideband_test.sv
// Self-checking bench for the sideband block and its power controller model.
// Assumes register reads answer in the cycle after the strobe.
`timescale 1ns/1ps
module csb_sideband_test
  import csb_pkg::*;
;
  logic        CLOCK, RESETN, WR, RD, SECURE_CFG_WRITE_LOCK, WAKE_EVENT_IN, L2_IDLE;
  logic        SEND_EVENT_OUT, L2_WFINT_STANDBY, SNOOP_INACTIVE, snoop_cmd;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, SHARED_IRQ_LINES, SHARED_IRQ_SYNC, v;
  logic [3:0]  FAST_IRQ_REQ_N, NORMAL_IRQ_REQ_N, VIRT_FAST_IRQ_REQ_N, VIRT_NORMAL_IRQ_REQ_N;
  logic [3:0]  DIST_FAST_IRQ, DIST_NORMAL_IRQ, FAST_IRQ_FWD_N, NORMAL_IRQ_FWD_N, CORE_WAKE;
  logic [3:0]  HYP_PHYS_TIMER_EVT_N, NONSEC_PHYS_TIMER_EVT_N, SEC_PHYS_TIMER_EVT_N;
  logic [3:0]  VIRT_TIMER_EVT_N, CORE_SEND_EVENT, CORE_WFI_ENTER, CORE_WFE_ENTER;
  logic [3:0]  CORE_WFINT_STANDBY, CORE_WFEVT_STANDBY, DEBUG_POWERUP_REQ, NO_POWERDOWN_FLAG;
  logic [3:0]  dbg_cmd, pd_req, core_off;
  logic [39:15] PERIPH_BASE_ADDR;
  logic [63:0] SYSTEM_COUNT_VALUE;
  csb_irq_t    CORE_IRQ_LEVELS, irq_cmd;
  csb_timer_t  TIMER_FIRE;
  int          failures, checks, n;

  csb_sideband #(.SHARED_N(31)) csb_sideband_i (
    .CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SECURE_CFG_WRITE_LOCK(SECURE_CFG_WRITE_LOCK),
    .SHARED_IRQ_LINES(SHARED_IRQ_LINES), .SHARED_IRQ_SYNC(SHARED_IRQ_SYNC),
    .FAST_IRQ_REQ_N(FAST_IRQ_REQ_N), .NORMAL_IRQ_REQ_N(NORMAL_IRQ_REQ_N),
    .VIRT_FAST_IRQ_REQ_N(VIRT_FAST_IRQ_REQ_N), .VIRT_NORMAL_IRQ_REQ_N(VIRT_NORMAL_IRQ_REQ_N),
    .DIST_FAST_IRQ(DIST_FAST_IRQ), .DIST_NORMAL_IRQ(DIST_NORMAL_IRQ),
    .FAST_IRQ_FWD_N(FAST_IRQ_FWD_N), .NORMAL_IRQ_FWD_N(NORMAL_IRQ_FWD_N),
    .CORE_IRQ_LEVELS(CORE_IRQ_LEVELS), .PERIPH_BASE_ADDR(PERIPH_BASE_ADDR),
    .TIMER_FIRE(TIMER_FIRE), .HYP_PHYS_TIMER_EVT_N(HYP_PHYS_TIMER_EVT_N),
    .NONSEC_PHYS_TIMER_EVT_N(NONSEC_PHYS_TIMER_EVT_N), .SEC_PHYS_TIMER_EVT_N(SEC_PHYS_TIMER_EVT_N),
    .VIRT_TIMER_EVT_N(VIRT_TIMER_EVT_N), .SYSTEM_COUNT_VALUE(SYSTEM_COUNT_VALUE),
    .WAKE_EVENT_IN(WAKE_EVENT_IN), .SEND_EVENT_OUT(SEND_EVENT_OUT),
    .CORE_SEND_EVENT(CORE_SEND_EVENT), .CORE_WFI_ENTER(CORE_WFI_ENTER),
    .CORE_WFE_ENTER(CORE_WFE_ENTER), .CORE_WAKE(CORE_WAKE),
    .CORE_WFINT_STANDBY(CORE_WFINT_STANDBY), .CORE_WFEVT_STANDBY(CORE_WFEVT_STANDBY),
    .L2_WFINT_STANDBY(L2_WFINT_STANDBY), .SNOOP_INACTIVE(SNOOP_INACTIVE), .L2_IDLE(L2_IDLE),
    .DEBUG_POWERUP_REQ(DEBUG_POWERUP_REQ), .NO_POWERDOWN_FLAG(NO_POWERDOWN_FLAG));

  csb_power_model csb_power_model_i (
    .clk(CLOCK), .rst_n(RESETN), .irq_cmd(irq_cmd), .snoop_cmd(snoop_cmd), .dbg_cmd(dbg_cmd),
    .pd_req(pd_req), .no_pd(NO_POWERDOWN_FLAG), .fast_n(FAST_IRQ_REQ_N),
    .normal_n(NORMAL_IRQ_REQ_N), .vfast_n(VIRT_FAST_IRQ_REQ_N), .vnorm_n(VIRT_NORMAL_IRQ_REQ_N),
    .snoop_out(SNOOP_INACTIVE), .dbg_out(DEBUG_POWERUP_REQ), .count(SYSTEM_COUNT_VALUE),
    .core_off(core_off));

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask

  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_raw(a, d);
    cmp(d, e);
  endtask

  // A hang anywhere ends the run as a failure
  initial begin
    repeat (20000) @(posedge CLOCK);
    failures++;
    close_out();
  end

  initial begin
    {RESETN, WR, RD, SECURE_CFG_WRITE_LOCK, WAKE_EVENT_IN, L2_IDLE, snoop_cmd} = 7'h0;
    {ADDR, WDATA, SHARED_IRQ_LINES} = 72'h0;
    {DIST_FAST_IRQ, DIST_NORMAL_IRQ, CORE_SEND_EVENT, CORE_WFI_ENTER} = 16'h0;
    {CORE_WFE_ENTER, dbg_cmd, pd_req} = 12'h0;
    irq_cmd = '0;
    TIMER_FIRE = '0;
    PERIPH_BASE_ADDR = 25'h1ABCDEF;
    repeat (12) @(posedge CLOCK);
    RESETN <= 1'b1;
    snoop_cmd <= 1'b1;
    dbg_cmd <= 4'hA;
    L2_IDLE <= 1'b1;
    repeat (8) @(posedge CLOCK);
    rd(CSB_CTRL_OFS, 32'h0);
    rd(CSB_BASE_OFS, 32'h01AB_CDEF);
    wr(CSB_CTRL_OFS, 32'h5);
    pd_req <= 4'hF;
    rd(CSB_CTRL_OFS, 32'h5);
    cmp(32'(core_off), 32'hA);
    rd(8'h1C, 32'h0);
    rd(CSB_SECCFG_OFS, CSB_SECCFG_RST);
    wr(CSB_SECCFG_OFS, 32'hA5A5_5A5A);
    rd(CSB_SECCFG_OFS, 32'hA5A5_5A5A);
    SECURE_CFG_WRITE_LOCK <= 1'b1;
    repeat (4) @(posedge CLOCK);
    wr(CSB_SECCFG_OFS, 32'h1234_0000);
    rd(CSB_SECCFG_OFS, 32'hA5A5_5A5A);
    SECURE_CFG_WRITE_LOCK <= 1'b0;
    pd_req <= 4'h0;
    for (int k = 0; k < 16; k++) begin
      TIMER_FIRE <= csb_timer_t'(16'h1 << k);
      DIST_FAST_IRQ <= 4'(k);
      DIST_NORMAL_IRQ <= ~4'(k);
      repeat (2) @(posedge CLOCK);
      #1 cmp(32'({HYP_PHYS_TIMER_EVT_N, NONSEC_PHYS_TIMER_EVT_N, SEC_PHYS_TIMER_EVT_N,
        VIRT_TIMER_EVT_N}), {16'h0, ~(16'h1 << k)});
      cmp(32'({FAST_IRQ_FWD_N, NORMAL_IRQ_FWD_N}), 32'({~4'(k), 4'(k)}));
    end
    {TIMER_FIRE, DIST_FAST_IRQ, DIST_NORMAL_IRQ} <= 24'h0;
    irq_cmd <= '{fast: 4'h1, normal: 4'h2, vfast: 4'h4, vnormal: 4'h8};
    SHARED_IRQ_LINES <= 32'h8000_0001;
    repeat (6) @(posedge CLOCK);
    rd(CSB_IRQLV_OFS, 32'h0001_8421);
    cmp(SHARED_IRQ_SYNC, 32'h8000_0001);
    irq_cmd <= '0;
    SHARED_IRQ_LINES <= 32'h0;
    repeat (6) @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h2;
    @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h0;
    CORE_SEND_EVENT <= 4'h4;
    #1 cmp(32'(CORE_WFEVT_STANDBY), 32'h2);
    @(posedge CLOCK);
    CORE_SEND_EVENT <= 4'h0;
    #1 cmp(32'({CORE_WFEVT_STANDBY, CORE_WAKE, SEND_EVENT_OUT}), 32'h05);
    @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h8;
    @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h0;
    #1 cmp(32'({CORE_WFEVT_STANDBY, CORE_WAKE}), 32'h08);
    @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h8;
    @(posedge CLOCK);
    CORE_WFE_ENTER <= 4'h0;
    WAKE_EVENT_IN <= 1'b1;
    #1 cmp(32'(CORE_WFEVT_STANDBY), 32'h8);
    for (n = 0; n < 8 && CORE_WFEVT_STANDBY !== 4'h0; n++) begin
      @(posedge CLOCK);
      #1;
    end
    cmp(32'(CORE_WFEVT_STANDBY), 32'h0);
    if (CORE_WFEVT_STANDBY !== 4'h0) close_out();
    WAKE_EVENT_IN <= 1'b0;
    @(posedge CLOCK);
    CORE_WFI_ENTER <= 4'hF;
    @(posedge CLOCK);
    CORE_WFI_ENTER <= 4'h0;
    #1 cmp(32'({CORE_WFINT_STANDBY, L2_WFINT_STANDBY}), 32'h1F);
    rd(CSB_STATUS_OFS, 32'h0000_A30F);
    L2_IDLE <= 1'b0;
    @(posedge CLOCK);
    #1 cmp(32'(L2_WFINT_STANDBY), 32'h0);
    irq_cmd <= '{fast: 4'h1, normal: 4'h0, vfast: 4'h0, vnormal: 4'h0};
    repeat (6) @(posedge CLOCK);
    #1 cmp(32'(CORE_WFINT_STANDBY), 32'hE);
    irq_cmd <= '0;
    rd_raw(CSB_CNTLO_OFS, v);
    rd(CSB_CNTHI_OFS, 32'h1234_5678);
    close_out();
  end
endmodule
